/* core/pvirq_defs.svh */
// Purpose: Register offsets, field positions, reset values, edge codes and priorities
// Assumes: Byte-wide register port, one clock
// Notes:   Included by the package and the top module
`ifndef PVIRQ_DEFS_SVH
`define PVIRQ_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define PVIRQ_OFS_KS_EDGE   8'h40
`define PVIRQ_OFS_PIN_EDGE  8'h41
`define PVIRQ_OFS_EXT_EN    8'h42
`define PVIRQ_OFS_EXT_REQ   8'h43
`define PVIRQ_OFS_INT_EN    8'h44
`define PVIRQ_OFS_INT_REQ   8'h45

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define PVIRQ_KS_EDGE_LSB   0
`define PVIRQ_PIN0_EDGE_LSB 0
`define PVIRQ_PIN1_EDGE_LSB 2
`define PVIRQ_PIN2_EDGE_LSB 4
`define PVIRQ_EDGE_REG_W    6
`define PVIRQ_EXT_LSB       0
`define PVIRQ_INT_TMR_LSB   0
`define PVIRQ_INT_HI_LSB    4
`define PVIRQ_SFR_IBIT      7
`define PVIRQ_RST_BYTE      8'h00

// ----------------------------------------------------------------------------
// Edge codes
// ----------------------------------------------------------------------------
`define PVIRQ_EDGE_NONE     2'h0
`define PVIRQ_EDGE_FALL     2'h1
`define PVIRQ_EDGE_RISE     2'h2
`define PVIRQ_EDGE_BOTH     2'h3

// ----------------------------------------------------------------------------
// Priorities (vector is twice the priority) and reset vector
// ----------------------------------------------------------------------------
`define PVIRQ_NSRC          10
`define PVIRQ_PRIO_KS       4'h1
`define PVIRQ_PRIO_PIN0     4'h2
`define PVIRQ_PRIO_PIN1     4'h3
`define PVIRQ_PRIO_PIN2     4'h4
`define PVIRQ_PRIO_T0       4'h6
`define PVIRQ_PRIO_T1       4'h7
`define PVIRQ_PRIO_T2       4'h8
`define PVIRQ_PRIO_ADC      4'ha
`define PVIRQ_PRIO_WDT      4'hb
`define PVIRQ_PRIO_VDI      4'hc
`define PVIRQ_RESET_VECTOR  0

`endif

/* core/pvirq_pkg.sv */
// Purpose: Types shared by the interrupt unit
// Assumes: pvirq_defs.svh provides the figures
// Notes:   Source index order equals priority order
`include "pvirq_defs.svh"

package pvirq_pkg;
  typedef logic [3:0] pvirq_src_t;
  typedef logic [`PVIRQ_NSRC-1:0] pvirq_vec_t;
  typedef enum logic [1:0] {
    ST_BOOT,
    ST_IDLE,
    ST_PREP
  } pvirq_state_t;
endpackage : pvirq_pkg

/* core/pvirq_stack_if.sv */
// Purpose: Push and pop carrier between the unit and one hardware stack
// Assumes: Push and pop never in the same cycle
// Notes:   Top is registered inside the stack
interface pvirq_stack_if #(parameter int W = 8);
  logic         push;
  logic         pop;
  logic [W-1:0] pushData;
  logic [W-1:0] top;
  modport owner (output push, output pop, output pushData, input top);
  modport store (input push, input pop, input pushData, output top);
endinterface : pvirq_stack_if

/* core/pvirq_stack.sv */
// Purpose: Circular hardware stack in flip-flops
// Assumes: Deeper nesting than DEPTH overwrites the oldest entry
// Notes:   Top of stack is held in its own flop
module pvirq_stack #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic         clk_sys,
  input wire logic         rst,
  // Stack port
  pvirq_stack_if.store     stk
);
  localparam int PW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << PW) != DEPTH) $error("pvirq_stack: DEPTH must be a power of two");
  end

  logic [W-1:0]  memReg [DEPTH];
  logic [PW-1:0] ptrReg;
  logic [W-1:0]  topReg;

  // ---------------------------------------------------------------------------
  // Storage and pointer
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ptrReg <= '0;
      topReg <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        memReg[i] <= '0;
      end
    end else if (stk.push) begin
      memReg[ptrReg] <= stk.pushData;
      ptrReg         <= ptrReg + 1'b1;
      topReg         <= stk.pushData;
    end else if (stk.pop) begin
      ptrReg <= ptrReg - 1'b1;
      topReg <= memReg[PW'(ptrReg - 2'd2)];
    end
  end

  assign stk.top = topReg;
endmodule : pvirq_stack

/* core/pvirq_unit.sv */
// Purpose: Prioritized vectored interrupt unit beside the processor core
// Assumes: Core marks instruction ends and pops both stacks on return
// Notes:   Register reads answer one cycle after the read strobe
//
// Overview of operation
// - Each source has fixed priority and vector, pin 0 at 2, indicator at 12.
// - Global mask 0 blocks all; mask 1 gates each source by its enable.
// - Request flag sets on the selected edge of the source, not level.
// - Accepted source's request flag clears during the entry step.
// - A set flag stays set until accepted or cleared by software.
// - Reset clears both request registers to zero.
// - Enable and request registers are readable and writable by software.
// - Key-scan edge code: 01 falling, 10 rising, 11 both.
// - Pin edge fields at bits 5:4, 3:2, 1:0; 00 selects none.
// - External enable register: pin2 bit3, pin1 bit2, pin0 bit1, key scan bit0.
// - External request register uses the same bit layout.
// - Internal enables: indicator 6, watchdog 5, converter 4, timers 2..0.
// - Internal request register uses the same bit layout.
// - Sampling within two machine cycles, then one preprocessing machine cycle.
// - Enable or disable instruction changes the mask immediately after it.
// - Acceptance clears the mask until the enable instruction or a return sets it.
// - Among simultaneous pending requests only the most urgent is accepted.
// - Acceptance pushes program counter (16 deep) and status (8 deep).
// - Same step loads the vector into the program counter.
// - After reset, execution starts at vector zero.
`include "pvirq_defs.svh"

module pvirq_unit #(
  parameter int MCYC_CLKS  = 4,
  parameter int PC_W       = 12,
  parameter int SFR_W      = 8,
  parameter int PSTK_DEPTH = 16,
  parameter int ISTK_DEPTH = 8
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Register port
  input  wire logic [7:0]        regAddr,
  input  wire logic [7:0]        regWrData,
  input  wire logic              regWrEn,
  input  wire logic              regRdEn,
  output logic      [7:0]        regRdData,
  // Interrupt sources
  input  wire logic              keyScanSource,
  input  wire logic              externalPinZero,
  input  wire logic              externalPinOne,
  input  wire logic              externalPinTwo,
  input  wire logic              timerZeroEvt,
  input  wire logic              timerOneEvt,
  input  wire logic              timerTwoEvt,
  input  wire logic              converterEvt,
  input  wire logic              watchdogEvt,
  input  wire logic              voltageIndicatorEvt,
  // Core side
  input  wire logic              instrEnd,
  input  wire logic              enableInterruptsInstr,
  input  wire logic              disableInterruptsInstr,
  input  wire logic              retiPop,
  input  wire logic [PC_W-1:0]   pcIn,
  input  wire logic [SFR_W-1:0]  statusFlagIn,
  output logic                   globalMask,
  output logic                   pcLoadEn,
  output logic      [PC_W-1:0]   pcLoadAddr,
  output logic                   acceptPulse,
  output pvirq_pkg::pvirq_src_t  acceptSrc,
  output logic      [PC_W-1:0]   pcStackTop,
  output logic      [SFR_W-1:0]  statusStackTop
);
  localparam int NS = `PVIRQ_NSRC;
  localparam int CW = $clog2(MCYC_CLKS + 1);
  localparam int PREP_MAX = 64;

  initial begin
    if (MCYC_CLKS < 1 || MCYC_CLKS >= PREP_MAX) $error("pvirq_unit: MCYC_CLKS out of range");
    if (PC_W < 5 || SFR_W <= `PVIRQ_SFR_IBIT) $error("pvirq_unit: PC_W or SFR_W too small");
  end

  pvirq_pkg::pvirq_state_t stateReg;
  pvirq_pkg::pvirq_vec_t   reqReg, reqNext, enReg, prevReg, hwSet, pending, ackClr, srcLvl;
  pvirq_pkg::pvirq_src_t   winIdx, prepIdx;
  logic [1:0]              edgeCode [NS];
  logic [1:0]              ksEdgeReg;
  logic [`PVIRQ_EDGE_REG_W-1:0] pinEdgeReg;
  logic [CW-1:0]           divReg;
  logic                    mcycEn, primedReg, sampleNow, vecStep;

  pvirq_stack_if #(.W(PC_W))  pcStk ();
  pvirq_stack_if #(.W(SFR_W)) stStk ();

  // ---------------------------------------------------------------------------
  // Vector table
  // ---------------------------------------------------------------------------
  function automatic logic [PC_W-1:0] vecOf(input pvirq_pkg::pvirq_src_t idx);
    logic [3:0] prio;
    prio = `PVIRQ_PRIO_VDI;
    case (idx)
      4'h0: prio = `PVIRQ_PRIO_KS;
      4'h1: prio = `PVIRQ_PRIO_PIN0;
      4'h2: prio = `PVIRQ_PRIO_PIN1;
      4'h3: prio = `PVIRQ_PRIO_PIN2;
      4'h4: prio = `PVIRQ_PRIO_T0;
      4'h5: prio = `PVIRQ_PRIO_T1;
      4'h6: prio = `PVIRQ_PRIO_T2;
      4'h7: prio = `PVIRQ_PRIO_ADC;
      4'h8: prio = `PVIRQ_PRIO_WDT;
      default: prio = `PVIRQ_PRIO_VDI;
    endcase
    return PC_W'({prio, 1'b0});
  endfunction : vecOf

  // ---------------------------------------------------------------------------
  // Machine cycle divider
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      divReg <= '0;
    end else if (divReg == CW'(MCYC_CLKS - 1)) begin
      divReg <= '0;
    end else begin
      divReg <= divReg + 1'b1;
    end
  end
  assign mcycEn = (divReg == CW'(MCYC_CLKS - 1));

  // ---------------------------------------------------------------------------
  // Edge detection
  // ---------------------------------------------------------------------------
  assign srcLvl = {voltageIndicatorEvt, watchdogEvt, converterEvt, timerTwoEvt, timerOneEvt,
                   timerZeroEvt, externalPinTwo, externalPinOne, externalPinZero, keyScanSource};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prevReg   <= '0;
      primedReg <= 1'b0;
    end else begin
      prevReg   <= srcLvl;
      primedReg <= 1'b1;
    end
  end

  always_comb begin
    edgeCode[0] = ksEdgeReg;
    edgeCode[1] = pinEdgeReg[`PVIRQ_PIN0_EDGE_LSB +: 2];
    edgeCode[2] = pinEdgeReg[`PVIRQ_PIN1_EDGE_LSB +: 2];
    edgeCode[3] = pinEdgeReg[`PVIRQ_PIN2_EDGE_LSB +: 2];
    for (int i = 4; i < NS; i++) begin
      edgeCode[i] = `PVIRQ_EDGE_RISE;
    end
  end

  for (genvar g = 0; g < NS; g++) begin : gEdge
    logic rise, fall;
    assign rise = srcLvl[g] & ~prevReg[g];
    assign fall = ~srcLvl[g] & prevReg[g];
    assign hwSet[g] = primedReg &
                      (((edgeCode[g] == `PVIRQ_EDGE_RISE) & rise) |
                       ((edgeCode[g] == `PVIRQ_EDGE_FALL) & fall) |
                       ((edgeCode[g] == `PVIRQ_EDGE_BOTH) & (rise | fall)));
  end

  // ---------------------------------------------------------------------------
  // Edge and enable registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ksEdgeReg  <= `PVIRQ_EDGE_NONE;
      pinEdgeReg <= '0;
      enReg      <= '0;
    end else if (regWrEn) begin
      if (regAddr == `PVIRQ_OFS_KS_EDGE) begin
        ksEdgeReg <= regWrData[`PVIRQ_KS_EDGE_LSB +: 2];
      end else if (regAddr == `PVIRQ_OFS_PIN_EDGE) begin
        pinEdgeReg <= regWrData[`PVIRQ_EDGE_REG_W-1:0];
      end else if (regAddr == `PVIRQ_OFS_EXT_EN) begin
        enReg[3:0] <= regWrData[`PVIRQ_EXT_LSB +: 4];
      end else if (regAddr == `PVIRQ_OFS_INT_EN) begin
        enReg[6:4] <= regWrData[`PVIRQ_INT_TMR_LSB +: 3];
        enReg[9:7] <= regWrData[`PVIRQ_INT_HI_LSB +: 3];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Request flags
  // ---------------------------------------------------------------------------
  always_comb begin
    reqNext = reqReg;
    if (regWrEn && regAddr == `PVIRQ_OFS_EXT_REQ) begin
      reqNext[3:0] = regWrData[`PVIRQ_EXT_LSB +: 4];
    end else if (regWrEn && regAddr == `PVIRQ_OFS_INT_REQ) begin
      reqNext[6:4] = regWrData[`PVIRQ_INT_TMR_LSB +: 3];
      reqNext[9:7] = regWrData[`PVIRQ_INT_HI_LSB +: 3];
    end
    // Held until accept or write; set wins
    reqNext = (reqNext & ~ackClr) | hwSet;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reqReg <= '0;
    end else begin
      reqReg <= reqNext;
    end
  end

  // ---------------------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      regRdData <= `PVIRQ_RST_BYTE;
    end else if (!regRdEn) begin
      regRdData <= `PVIRQ_RST_BYTE;
    end else if (regAddr == `PVIRQ_OFS_EXT_EN) begin
      regRdData <= {4'h0, enReg[3:0]};
    end else if (regAddr == `PVIRQ_OFS_EXT_REQ) begin
      regRdData <= {4'h0, reqReg[3:0]};
    end else if (regAddr == `PVIRQ_OFS_INT_EN) begin
      regRdData <= {1'b0, enReg[9:7], 1'b0, enReg[6:4]};
    end else if (regAddr == `PVIRQ_OFS_INT_REQ) begin
      regRdData <= {1'b0, reqReg[9:7], 1'b0, reqReg[6:4]};
    end else begin
      regRdData <= `PVIRQ_RST_BYTE;
    end
  end

  // ---------------------------------------------------------------------------
  // Arbitration
  // ---------------------------------------------------------------------------
  // Mask then individual enable
  assign pending = reqReg & enReg & {NS{globalMask}};

  always_comb begin
    winIdx = '0;
    for (int i = NS - 1; i >= 0; i--) begin
      if (pending[i]) winIdx = pvirq_pkg::pvirq_src_t'(i);
    end
  end

  assign sampleNow = (stateReg == pvirq_pkg::ST_IDLE) && mcycEn && instrEnd && (|pending);
  assign vecStep   = (stateReg == pvirq_pkg::ST_PREP) && mcycEn;

  always_comb begin
    ackClr = '0;
    if (vecStep) ackClr[prepIdx] = 1'b1;
  end

  // ---------------------------------------------------------------------------
  // Entry sequence
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stateReg    <= pvirq_pkg::ST_BOOT;
      prepIdx     <= '0;
      pcLoadEn    <= 1'b0;
      pcLoadAddr  <= '0;
      acceptPulse <= 1'b0;
      acceptSrc   <= '0;
    end else begin
      pcLoadEn    <= 1'b0;
      acceptPulse <= 1'b0;
      case (stateReg)
        pvirq_pkg::ST_BOOT: begin
          pcLoadEn   <= 1'b1;
          pcLoadAddr <= PC_W'(`PVIRQ_RESET_VECTOR);
          stateReg   <= pvirq_pkg::ST_IDLE;
        end
        pvirq_pkg::ST_IDLE: begin
          if (sampleNow) begin
            prepIdx  <= winIdx;
            stateReg <= pvirq_pkg::ST_PREP;
          end
        end
        pvirq_pkg::ST_PREP: begin
          if (vecStep) begin
            pcLoadEn    <= 1'b1;
            pcLoadAddr  <= vecOf(prepIdx);
            acceptPulse <= 1'b1;
            acceptSrc   <= prepIdx;
            stateReg    <= pvirq_pkg::ST_IDLE;
          end
        end
        default: stateReg <= pvirq_pkg::ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Global mask
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      globalMask <= 1'b0;
    end else if (sampleNow) begin
      globalMask <= 1'b0;
    end else if (retiPop && stateReg == pvirq_pkg::ST_IDLE) begin
      globalMask <= stStk.top[`PVIRQ_SFR_IBIT];
    end else if (enableInterruptsInstr) begin
      globalMask <= 1'b1;
    end else if (disableInterruptsInstr) begin
      globalMask <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Stacks
  // ---------------------------------------------------------------------------
  always_comb begin
    pcStk.push     = vecStep;
    stStk.push     = vecStep;
    pcStk.pop      = retiPop && !vecStep;
    stStk.pop      = retiPop && !vecStep;
    pcStk.pushData = pcIn;
    stStk.pushData = statusFlagIn;
    stStk.pushData[`PVIRQ_SFR_IBIT] = 1'b1;
  end

  pvirq_stack #(.W(PC_W), .DEPTH(PSTK_DEPTH)) uPcStack (
    .clk_sys (clk_sys),
    .rst     (rst),
    .stk     (pcStk.store)
  );

  pvirq_stack #(.W(SFR_W), .DEPTH(ISTK_DEPTH)) uStatusStack (
    .clk_sys (clk_sys),
    .rst     (rst),
    .stk     (stStk.store)
  );

  assign pcStackTop     = pcStk.top;
  assign statusStackTop = stStk.top;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  sequence sSample;
    (stateReg == pvirq_pkg::ST_IDLE) && mcycEn && instrEnd && (|pending);
  endsequence

  sequence sEntry;
    ##[1:PREP_MAX] acceptPulse;
  endsequence

  AST_PREP_STEP: assert property (@(posedge clk_sys) disable iff (rst)
    sSample |-> sEntry)
    else $error("entry step did not follow sampling");

  AST_MASK_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
    sSample |=> !globalMask)
    else $error("mask not cleared on acceptance");

  AST_MASK_BLOCK: assert property (@(posedge clk_sys) disable iff (rst)
    !globalMask && stateReg == pvirq_pkg::ST_IDLE |=> stateReg != pvirq_pkg::ST_PREP)
    else $error("interrupt taken while masked");

  AST_WINNER: assert property (@(posedge clk_sys) disable iff (rst)
    sSample |-> pending[winIdx] && (pending & ~({NS{1'b1}} << winIdx)) == '0
                ##1 prepIdx == $past(winIdx))
    else $error("wrong source chosen");

  AST_VECTOR: assert property (@(posedge clk_sys) disable iff (rst)
    acceptPulse |-> pcLoadEn && pcLoadAddr == vecOf(acceptSrc))
    else $error("vector not loaded");

  AST_PUSH_PC: assert property (@(posedge clk_sys) disable iff (rst)
    acceptPulse |-> pcStackTop == $past(pcIn))
    else $error("program counter not pushed");

  AST_ACK_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
    vecStep && !hwSet[prepIdx] |=> !reqReg[prepIdx])
    else $error("accepted flag not cleared");

  AST_FLAG_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
    reqReg[0] && !ackClr[0] && !(regWrEn && regAddr == `PVIRQ_OFS_EXT_REQ) |=> reqReg[0])
    else $error("request flag dropped");

  AST_TIMER_EDGE: assert property (@(posedge clk_sys) disable iff (rst)
    primedReg && timerZeroEvt && !prevReg[4] |=> reqReg[4])
    else $error("timer edge not flagged");

  AST_EDGE_NONE: assert property (@(posedge clk_sys) disable iff (rst)
    pinEdgeReg[`PVIRQ_PIN0_EDGE_LSB +: 2] == `PVIRQ_EDGE_NONE |-> !hwSet[1])
    else $error("edge set with code none");

  AST_RESET_CLEAR: assert property (@(posedge clk_sys)
    rst && $past(rst) |-> reqReg == '0)
    else $error("request flags not cleared in reset");

  AST_BOOT: assert property (@(posedge clk_sys)
    $fell(rst) |=> pcLoadEn && pcLoadAddr == '0)
    else $error("reset vector not loaded");

  AST_EI: assert property (@(posedge clk_sys) disable iff (rst)
    enableInterruptsInstr && !sampleNow && !retiPop |=> globalMask)
    else $error("enable instruction did not set mask");
endmodule : pvirq_unit

/* bench/pvirq_core_model.sv */
// Purpose: Processor core stand-in facing the interrupt unit
// Assumes: Every instruction takes two clocks
// Notes:   Each handler returns four clocks after its vector load
module pvirq_core_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Vector load from the unit
  input  wire logic        pcLoadEn,
  input  wire logic [11:0] pcLoadAddr,
  // Core status toward the unit
  output logic             instrEnd,
  output logic             retiPop,
  output logic      [11:0] pcIn,
  output logic      [7:0]  statusFlagIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] svcCnt_reg;
  assign pcIn         = 12'h5a3;
  assign statusFlagIn = 8'h21;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      svcCnt_reg <= 3'h0;
      retiPop    <= 1'b0;
      instrEnd   <= 1'b0;
    end else begin
      retiPop  <= (svcCnt_reg == 3'h1);
      instrEnd <= ~instrEnd;
      if (pcLoadEn && pcLoadAddr != 12'h000) begin
        svcCnt_reg <= 3'h4;
      end else if (svcCnt_reg != 3'h0) begin
        svcCnt_reg <= svcCnt_reg - 3'h1;
      end
    end
  end
endmodule : pvirq_core_model

/* bench/pvirq_unit_test.sv */
// Purpose: Self-checking bench for the interrupt unit
// Assumes: One clock per machine cycle
// Notes:   Prints mismatches and the verdict only
module pvirq_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [7:0]  regWrData = 8'h00;
  logic        regWrEn = 1'b0;
  logic        regRdEn = 1'b0;
  logic        eiInstr = 1'b0;
  logic        diInstr = 1'b0;
  logic [3:0]  extPins = 4'h0;
  logic [5:0]  intEvt = 6'h00;
  logic [7:0]  regRdData, statusFlagIn, statusStackTop, q;
  logic [11:0] pcIn, pcLoadAddr, pcStackTop;
  logic        instrEnd, retiPop, globalMask, pcLoadEn, acceptPulse;
  pvirq_pkg::pvirq_src_t acceptSrc;
  int          n_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          lat;
  logic [23:0] rows [11] = '{24'h42ff0f, 24'h430f0f, 24'h44ff77, 24'h45ff77, 24'h400300,
    24'h413f00, 24'h5aff00, 24'h430000, 24'h450000, 24'h420000, 24'h440000};
  logic [3:0]  srcs [3] = '{4'h1, 4'h4, 4'h9};
  logic [11:0] vecs [3] = '{12'h004, 12'h00c, 12'h018};

  pvirq_unit #(.MCYC_CLKS(1)) pvirq_unit_inst (
    .clk_sys, .rst, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
    .keyScanSource(extPins[0]), .externalPinZero(extPins[1]),
    .externalPinOne(extPins[2]), .externalPinTwo(extPins[3]),
    .timerZeroEvt(intEvt[0]), .timerOneEvt(intEvt[1]), .timerTwoEvt(intEvt[2]),
    .converterEvt(intEvt[3]), .watchdogEvt(intEvt[4]), .voltageIndicatorEvt(intEvt[5]),
    .instrEnd, .enableInterruptsInstr(eiInstr), .disableInterruptsInstr(diInstr),
    .retiPop, .pcIn, .statusFlagIn, .globalMask, .pcLoadEn, .pcLoadAddr,
    .acceptPulse, .acceptSrc, .pcStackTop, .statusStackTop);

  pvirq_core_model pvirq_core_model_inst (
    .clk_sys, .rst, .pcLoadEn, .pcLoadAddr, .instrEnd, .retiPop, .pcIn, .statusFlagIn);

  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      complete_run();
    end
  end

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    #1;
    q = regRdData;
  endtask : rd

  task ins(input logic e);
    @(posedge clk_sys);
    eiInstr <= e;
    diInstr <= !e;
    @(posedge clk_sys);
    eiInstr <= 1'b0;
    diInstr <= 1'b0;
    #1;
    chk("mask", 16'(e), 16'(globalMask));
  endtask : ins

  task waitAcc(output int k);
    k = 0;
    do begin
      @(posedge clk_sys);
      #1;
      k++;
    end while (acceptPulse !== 1'b1 && k < 60);
  endtask : waitAcc

  task complete_run;
    if (n_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    tick(16);
    rst <= 1'b0;
    tick(1);
    #1;
    chk("boot load", 16'h1, 16'(pcLoadEn));
    chk("boot vector", 16'h0, 16'(pcLoadAddr));
    for (int i = 0; i < 4; i++) begin
      rd(8'h42 + 8'(i));
      chk("reset byte", 16'h0, 16'(q));
    end
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16]);
      chk("reg row", 16'(rows[i][7:0]), 16'(q));
    end
    for (int c = 0; c < 4; c++) begin
      wr(8'h40, 8'(c));
      wr(8'h41, {2'h0, 2'(c), 2'(c), 2'(c)});
      extPins <= 4'hf;
      tick(2);
      rd(8'h43);
      chk("rise flags", c[1] ? 16'hf : 16'h0, 16'(q));
      wr(8'h43, 8'h00);
      extPins <= 4'h0;
      tick(2);
      rd(8'h43);
      chk("fall flags", c[0] ? 16'hf : 16'h0, 16'(q));
      wr(8'h43, 8'h00);
    end
    wr(8'h42, 8'h02);
    wr(8'h44, 8'h41);
    wr(8'h43, 8'h06);
    intEvt <= 6'h21;
    tick(3);
    intEvt <= 6'h00;
    tick(3);
    rd(8'h45);
    chk("held flags", 16'h41, 16'(q));
    ins(1'b1);
    for (int i = 0; i < 3; i++) begin
      waitAcc(lat);
      chk("accept", 16'h1, 16'(acceptPulse));
      if (i == 0) chk("entry delay", 16'h1, 16'(lat >= 2 && lat <= 3));
      chk("source", 16'(srcs[i]), 16'(acceptSrc));
      chk("vector", 16'(vecs[i]), 16'(pcLoadAddr & {12{pcLoadEn}}));
      chk("pc saved", 16'h5a3, 16'(pcStackTop));
      chk("status saved", 16'ha1, 16'(statusStackTop));
      chk("mask off", 16'h0, 16'(globalMask));
    end
    tick(8);
    rd(8'h43);
    chk("ext left", 16'h4, 16'(q));
    rd(8'h45);
    chk("int left", 16'h0, 16'(q));
    ins(1'b0);
    complete_run();
  end
endmodule : pvirq_unit_test
